// [pkg/hmpic_pkg.sv]
// constants, field layouts and codes of the host memory port input control block
package hmpic_pkg;
   // register indices and byte addresses
   localparam logic [7:0] MAC_IDX = 8'h02;
   localparam logic [7:0] ICR_IDX = 8'h03;
   localparam logic [7:0] ADDR_MAC = MAC_IDX << 2;
   localparam logic [7:0] ADDR_ICR = ICR_IDX << 2;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [7:0] ADDR_CANVAS = 8'h18;
   localparam logic [7:0] ADDR_STATE = 8'h1C;
   // reset values and mac write mask
   localparam logic [7:0] MAC_RST = 8'h00;
   localparam logic [7:0] ICR_RST = 8'h00;
   localparam logic [7:0] MAC_WMASK = 8'hF6;
   // field positions
   localparam int MAC_FMT_LSB = 6;
   localparam int MAC_RDIR_LSB = 4;
   localparam int MAC_WDIR_LSB = 1;
   localparam int ICR_POL_BIT = 7;
   localparam int ICR_DEB_BIT = 6;
   localparam int ICR_TRIG_LSB = 4;
   localparam int ICR_TEXT_BIT = 2;
   localparam int ICR_DEST_LSB = 0;
   // interrupt status bits
   localparam int IRQ_EXT_BIT = 0;
   localparam int IRQ_REFUSED_BIT = 1;
   // debounce span in oscillator clocks, one per pclk here
   localparam int DEB_OSC_CLOCKS = 1024;
   localparam logic [9:0] DEB_LAST = 10'(DEB_OSC_CLOCKS - 1);
   // trigger codes
   localparam logic [1:0] TRIG_LOW = 2'h0;
   localparam logic [1:0] TRIG_FALL = 2'h1;
   localparam logic [1:0] TRIG_HIGH = 2'h2;
   localparam logic [1:0] TRIG_RISE = 2'h3;
   // image data format codes
   localparam logic [1:0] FMT_MASK_ALL = 2'h2;
   localparam logic [1:0] FMT_MASK_EVEN = 2'h3;
   // destination codes and original direction code
   localparam logic [1:0] DEST_IMAGE = 2'h0;
   localparam logic [1:0] DEST_GAMMA = 2'h1;
   localparam logic [1:0] DEST_CURSOR = 2'h2;
   localparam logic [1:0] DEST_PALETTE = 2'h3;
   localparam logic [1:0] DIR_ORIGINAL = 2'h0;
   // apb slave states
   typedef enum logic [2:0] {
      APB_IDLE = 3'b001,
      APB_ACC = 3'b010,
      APB_RDY = 3'b100
   } hmpic_apb_e;
endpackage : hmpic_pkg

// [pkg/hmpic_port_if.sv]
// memory data port request and answer between control and routing
`timescale 1ns/10ps
interface hmpic_port_if;
   logic req_valid;
   logic req_write;
   logic [15:0] req_data;
   logic req_odd;
   logic [1:0] dest;
   logic [1:0] fmt;
   logic wr_stb;
   logic rd_stb;
   logic refused;
   logic [15:0] wr_data;
   logic [1:0] be;
   modport ctrl (output req_valid, req_write, req_data, req_odd, dest, fmt,
                 input wr_stb, rd_stb, refused, wr_data, be);
   modport route (input req_valid, req_write, req_data, req_odd, dest, fmt,
                  output wr_stb, rd_stb, refused, wr_data, be);
endinterface : hmpic_port_if

// [core/hmpic_debounce.sv]
// debounce filter for the external interrupt input
`timescale 1ns/10ps
module hmpic_debounce (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control and signal
   input wire logic enable,
   input wire logic raw_in,
   output logic clean_out
);
   logic [9:0] cnt_q, cnt_d;
   logic out_q, out_d;

   // new level accepted only after a full quiet span
   always_comb
   begin
      cnt_d = 10'h000;
      out_d = out_q;
      if (!enable)
         out_d = raw_in;
      else if (raw_in != out_q)
      begin
         if (cnt_q == hmpic_pkg::DEB_LAST)
            out_d = raw_in;
         else
            cnt_d = cnt_q + 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 10'h000;
         out_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign clean_out = out_q;
endmodule : hmpic_debounce

// [core/hmpic_route.sv]
// shapes memory data port accesses by format and destination
`timescale 1ns/10ps
module hmpic_route (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // request and answer
   hmpic_port_if.route pif
);
   logic wr_q, wr_d, rd_q, rd_d, ref_q, ref_d;
   logic [15:0] data_q, data_d;
   logic [1:0] be_q, be_d;

   // byte lanes and refusal worked out per access
   always_comb
   begin
      wr_d = 1'b0;
      rd_d = 1'b0;
      ref_d = 1'b0;
      data_d = pif.req_data;
      be_d = 2'h3;
      if (pif.fmt == hmpic_pkg::FMT_MASK_ALL)
         be_d = 2'h1;
      else if (pif.fmt == hmpic_pkg::FMT_MASK_EVEN && !pif.req_odd)
         be_d = 2'h1;
      if (pif.dest != hmpic_pkg::DEST_IMAGE)
         be_d = 2'h1;
      if (pif.dest == hmpic_pkg::DEST_PALETTE && !pif.req_odd)
         data_d[7:4] = 4'h0;
      if (be_d == 2'h1)
         data_d[15:8] = 8'h00;
      if (pif.req_valid)
      begin
         if (pif.req_write)
            wr_d = 1'b1;
         else if (pif.dest == hmpic_pkg::DEST_CURSOR || pif.dest == hmpic_pkg::DEST_PALETTE)
            ref_d = 1'b1;
         else
            rd_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         ref_q <= 1'b0;
         data_q <= 16'h0000;
         be_q <= 2'h0;
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         ref_q <= ref_d;
         data_q <= data_d;
         be_q <= be_d;
      end
   end

   assign pif.wr_stb = wr_q;
   assign pif.rd_stb = rd_q;
   assign pif.refused = ref_q;
   assign pif.wr_data = data_q;
   assign pif.be = be_q;
endmodule : hmpic_route

// [core/hmpic_top.sv]
// register bank and control of the host memory port and input control
`timescale 1ns/10ps
module hmpic_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external interrupt input and interrupt pin
   input wire logic external_interrupt_input,
   output logic intr_pin,
   // memory data port from the host bus
   input wire logic hp_valid,
   input wire logic hp_write,
   input wire logic [15:0] hp_data,
   // shaped access towards the memories
   output logic mem_wr,
   output logic mem_rd,
   output logic mem_refused,
   output logic [15:0] mem_data,
   output logic [1:0] mem_be,
   output logic [1:0] mem_dest,
   // decoded controls for the datapaths
   output logic [1:0] img_format,
   output logic [1:0] read_dir,
   output logic [1:0] write_dir,
   output logic text_mode
);
   hmpic_pkg::hmpic_apb_e st_q, st_d;
   logic [7:0] mac_q, mac_d, icr_q, icr_d;
   logic [1:0] stat_q, stat_d, mask_q, mask_d;
   logic linear_q, linear_d;
   logic [31:0] rdata_q, rdata_d;
   logic rdy_q, rdy_d, err_q, err_d;
   logic intr_q, intr_d;
   logic ext_prev_q, ext_prev_d, odd_q, odd_d;
   logic [1:0] dest_q, dest_d;
   logic [1:0] fmt_q, fmt_d, rdir_q, rdir_d, wdir_q, wdir_d;
   logic text_q, text_d;
   logic ext_clean, ext_event, wr_take, mapped, any_irq;
   logic [7:0] icr_view;
   hmpic_port_if port_if();

   // external interrupt conditioning
   hmpic_debounce u_deb (
      .pclk(pclk),
      .presetn(presetn),
      .enable(icr_q[hmpic_pkg::ICR_DEB_BIT]),
      .raw_in(external_interrupt_input),
      .clean_out(ext_clean)
   );

   // access shaping by format and destination
   hmpic_route u_route (
      .pclk(pclk),
      .presetn(presetn),
      .pif(port_if)
   );

   // request side of the port goes straight to routing
   assign port_if.req_valid = hp_valid;
   assign port_if.req_write = hp_write;
   assign port_if.req_data = hp_data;
   assign port_if.req_odd = odd_q;
   assign port_if.dest = dest_q;
   assign port_if.fmt = fmt_q;

   // text bit reads back as graphic while canvas is linear
   always_comb
   begin
      icr_view = icr_q;
      if (linear_q)
         icr_view[hmpic_pkg::ICR_TEXT_BIT] = 1'b0;
   end

   // trigger type selects level or edge on the conditioned input
   always_comb
   begin
      case (icr_q[hmpic_pkg::ICR_TRIG_LSB +: 2])
         hmpic_pkg::TRIG_LOW: ext_event = !ext_clean;
         hmpic_pkg::TRIG_FALL: ext_event = ext_prev_q && !ext_clean;
         hmpic_pkg::TRIG_HIGH: ext_event = ext_clean;
         hmpic_pkg::TRIG_RISE: ext_event = !ext_prev_q && ext_clean;
         default: ext_event = 1'b0;
      endcase
   end

   // address decode
   assign mapped = (paddr == hmpic_pkg::ADDR_MAC) || (paddr == hmpic_pkg::ADDR_ICR)
      || (paddr == hmpic_pkg::ADDR_IRQ_STAT) || (paddr == hmpic_pkg::ADDR_IRQ_MASK)
      || (paddr == hmpic_pkg::ADDR_CANVAS) || (paddr == hmpic_pkg::ADDR_STATE);
   assign wr_take = (st_q == hmpic_pkg::APB_RDY) && psel && penable && pwrite;

   // apb handshake: one wait cycle so read data is settled with pready
   always_comb
   begin
      st_d = st_q;
      rdy_d = 1'b0;
      err_d = 1'b0;
      rdata_d = 32'h0000_0000;
      case (st_q)
         hmpic_pkg::APB_IDLE:
         begin
            if (psel && !penable)
               st_d = hmpic_pkg::APB_ACC;
         end
         hmpic_pkg::APB_ACC:
         begin
            if (psel && penable)
            begin
               st_d = hmpic_pkg::APB_RDY;
               rdy_d = 1'b1;
               err_d = !mapped;
               if (!pwrite)
               begin
                  case (paddr)
                     hmpic_pkg::ADDR_MAC: rdata_d = {24'h000000, mac_q};
                     hmpic_pkg::ADDR_ICR: rdata_d = {24'h000000, icr_view};
                     hmpic_pkg::ADDR_IRQ_STAT: rdata_d = {30'h0000_0000, stat_q};
                     hmpic_pkg::ADDR_IRQ_MASK: rdata_d = {30'h0000_0000, mask_q};
                     hmpic_pkg::ADDR_CANVAS: rdata_d = {31'h0000_0000, linear_q};
                     hmpic_pkg::ADDR_STATE: rdata_d = {30'h0000_0000, odd_q, ext_clean};
                     default: rdata_d = 32'h0000_0000;
                  endcase
               end
            end
            else
               st_d = hmpic_pkg::APB_IDLE;
         end
         hmpic_pkg::APB_RDY:
         begin
            if (psel && !penable)
               st_d = hmpic_pkg::APB_ACC;
            else
               st_d = hmpic_pkg::APB_IDLE;
         end
         default: st_d = hmpic_pkg::APB_IDLE;
      endcase
   end

   // register writes; unmapped writes change nothing
   always_comb
   begin
      mac_d = mac_q;
      icr_d = icr_q;
      mask_d = mask_q;
      linear_d = linear_q;
      if (wr_take)
      begin
         case (paddr)
            hmpic_pkg::ADDR_MAC: mac_d = pwdata[7:0] & hmpic_pkg::MAC_WMASK;
            hmpic_pkg::ADDR_ICR: icr_d = pwdata[7:0];
            hmpic_pkg::ADDR_IRQ_MASK: mask_d = pwdata[1:0];
            hmpic_pkg::ADDR_CANVAS: linear_d = pwdata[0];
            default: mac_d = mac_q;
         endcase
      end
   end

   // sticky status: a new event beats a write-one clear in the same cycle
   always_comb
   begin
      stat_d = stat_q;
      if (wr_take && paddr == hmpic_pkg::ADDR_IRQ_STAT)
         stat_d = stat_q & ~pwdata[1:0];
      if (ext_event)
         stat_d[hmpic_pkg::IRQ_EXT_BIT] = 1'b1;
      if (port_if.refused)
         stat_d[hmpic_pkg::IRQ_REFUSED_BIT] = 1'b1;
   end

   // pin level from unmasked status and polarity bit
   assign any_irq = |(stat_q & mask_q);
   always_comb
   begin
      if (icr_q[hmpic_pkg::ICR_POL_BIT])
         intr_d = any_irq;
      else
         intr_d = !any_irq;
   end

   // word parity restarts whenever the control register is written,
   // so the first word after a destination change counts as even
   always_comb
   begin
      odd_d = odd_q;
      if (wr_take && paddr == hmpic_pkg::ADDR_ICR)
         odd_d = 1'b0;
      else if (hp_valid)
         odd_d = !odd_q;
      ext_prev_d = ext_clean;
   end

   // decoded controls; linear canvas turns off direction and text mode
   always_comb
   begin
      fmt_d = mac_q[hmpic_pkg::MAC_FMT_LSB +: 2];
      rdir_d = mac_q[hmpic_pkg::MAC_RDIR_LSB +: 2];
      wdir_d = mac_q[hmpic_pkg::MAC_WDIR_LSB +: 2];
      if (linear_q)
      begin
         rdir_d = hmpic_pkg::DIR_ORIGINAL;
         wdir_d = hmpic_pkg::DIR_ORIGINAL;
      end
      text_d = icr_view[hmpic_pkg::ICR_TEXT_BIT];
      dest_d = icr_q[hmpic_pkg::ICR_DEST_LSB +: 2];
   end

   // apb answer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= hmpic_pkg::APB_IDLE;
         rdata_q <= 32'h0000_0000;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         rdata_q <= rdata_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
      end
   end

   // software visible registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mac_q <= hmpic_pkg::MAC_RST;
         icr_q <= hmpic_pkg::ICR_RST;
         mask_q <= 2'h0;
         linear_q <= 1'b0;
      end
      else
      begin
         mac_q <= mac_d;
         icr_q <= icr_d;
         mask_q <= mask_d;
         linear_q <= linear_d;
      end
   end

   // sticky interrupt status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stat_q <= 2'h0;
      end
      else
      begin
         stat_q <= stat_d;
      end
   end

   // pin resets to the idle level of a low-active line
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         intr_q <= 1'b1;
      end
      else
      begin
         intr_q <= intr_d;
      end
   end

   // word parity and last conditioned input
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_prev_q <= 1'b0;
         odd_q <= 1'b0;
      end
      else
      begin
         ext_prev_q <= ext_prev_d;
         odd_q <= odd_d;
      end
   end

   // decoded controls, one cycle behind the registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dest_q <= 2'h0;
         fmt_q <= 2'h0;
         rdir_q <= 2'h0;
         wdir_q <= 2'h0;
         text_q <= 1'b0;
      end
      else
      begin
         dest_q <= dest_d;
         fmt_q <= fmt_d;
         rdir_q <= rdir_d;
         wdir_q <= wdir_d;
         text_q <= text_d;
      end
   end

   // outputs, each from a flip-flop
   assign prdata = rdata_q;
   assign pready = rdy_q;
   assign pslverr = err_q;
   assign intr_pin = intr_q;
   assign mem_wr = port_if.wr_stb;
   assign mem_rd = port_if.rd_stb;
   assign mem_refused = port_if.refused;
   assign mem_data = port_if.wr_data;
   assign mem_be = port_if.be;
   assign mem_dest = dest_q;
   assign img_format = fmt_q;
   assign read_dir = rdir_q;
   assign write_dir = wdir_q;
   assign text_mode = text_q;
endmodule : hmpic_top

// [verification/hmpic_host_model.sv]
// host-side model that drives the memory data port
`timescale 1ns/10ps
module hmpic_host_model (
   // clock
   input wire logic pclk,
   // memory data port
   output logic hp_valid,
   output logic hp_write,
   output logic [15:0] hp_data
);
   // idle at time zero
   initial
   begin
      hp_valid = 1'h0;
      hp_write = 1'h0;
      hp_data = 16'h0000;
   end
   // one word per call; idle data shows the inverse so a stale word never passes
   // reads are strobes only, so the first read after a port switch carries no data
   task automatic access(input logic wr, input logic [15:0] d);
      @(posedge pclk);
      hp_valid <= 1'h1;
      hp_write <= wr;
      hp_data <= d;
      @(posedge pclk);
      hp_valid <= 1'h0;
      hp_data <= ~d;
   endtask : access
endmodule : hmpic_host_model

// [verification/hmpic_asserts.sv]
// port assertions for the host memory port control block
`timescale 1ns/10ps
module hmpic_asserts (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb answer
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // host port and shaped side
   input wire logic hp_valid,
   input wire logic hp_write,
   input wire logic [15:0] hp_data,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic mem_refused,
   input wire logic [15:0] mem_data,
   input wire logic [1:0] mem_be,
   input wire logic [1:0] mem_dest,
   input wire logic [1:0] img_format
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // waiting access phase, host write, host read
   sequence s_acc;
      psel && penable && !pready;
   endsequence
   sequence s_wr;
      hp_valid && hp_write;
   endsequence
   sequence s_rd;
      hp_valid && !hp_write;
   endsequence
   chk_apb_wait: assert property (s_acc |=> pready)
      else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   chk_err_qual: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   chk_wr_pulse: assert property (s_wr |=> mem_wr && !mem_rd && !mem_refused)
      else $error("no shaped write");
   chk_rd_image: assert property (s_rd ##0 (mem_dest == hmpic_pkg::DEST_IMAGE) |=> mem_rd)
      else $error("image read lost");
   chk_rd_refused: assert property (s_rd ##0 mem_dest[1] |=> mem_refused && !mem_rd)
      else $error("read not refused");
   chk_mask_all: assert property (s_wr ##0 (img_format == hmpic_pkg::FMT_MASK_ALL)
      |=> mem_data[15:8] == 8'h00)
      else $error("high byte kept");
   chk_cursor_low: assert property (s_wr ##0 (mem_dest == hmpic_pkg::DEST_CURSOR)
      |=> mem_be == 2'h1 && mem_data[15:8] == 8'h00)
      else $error("cursor high byte");
   chk_direct_pass: assert property (s_wr ##0 (!img_format[1] && mem_dest == hmpic_pkg::DEST_IMAGE)
      |=> mem_data == $past(hp_data) && mem_be == 2'h3)
      else $error("direct word altered");
endmodule : hmpic_asserts
bind hmpic_top hmpic_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .hp_valid(hp_valid), .hp_write(hp_write), .hp_data(hp_data),
   .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_refused(mem_refused), .mem_data(mem_data),
   .mem_be(mem_be), .mem_dest(mem_dest), .img_format(img_format));

// [verification/host_memory_port_input_control_test.sv]
// self-checking bench for the host memory port control block
`timescale 1ns/10ps
module host_memory_port_input_control_test;
   localparam logic [7:0] A_MAC = hmpic_pkg::ADDR_MAC;
   localparam logic [7:0] A_ICR = hmpic_pkg::ADDR_ICR;
   localparam logic [7:0] A_STA = hmpic_pkg::ADDR_IRQ_STAT;
   localparam logic [7:0] A_MSK = hmpic_pkg::ADDR_IRQ_MASK;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext, intr_pin, err_q;
   logic hp_valid, hp_write, mem_wr, mem_rd, mem_refused, text_mode;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] hp_data, mem_data;
   logic [1:0] mem_be, mem_dest, img_format, read_dir, write_dir;
   int bad_count = 0;
   int checks_done = 0;
   hmpic_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_interrupt_input(ext), .intr_pin(intr_pin), .hp_valid(hp_valid), .hp_write(hp_write),
      .hp_data(hp_data), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_refused(mem_refused),
      .mem_data(mem_data), .mem_be(mem_be), .mem_dest(mem_dest), .img_format(img_format),
      .read_dir(read_dir), .write_dir(write_dir), .text_mode(text_mode));
   hmpic_host_model host (.pclk(pclk), .hp_valid(hp_valid), .hp_write(hp_write), .hp_data(hp_data));
   // 50 MHz clock
   initial
   begin
      pclk = 1'h0;
      forever #10 pclk = ~pclk;
   end
   // verdict and stop
   task automatic end_sim;
      if (bad_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   // one comparison
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      q = prdata;
      err_q = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 20)
      begin
         bad_count++;
         $display("FAIL pready expected 1 seen %b", pready);
         end_sim;
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'h0, a, 32'h0);
      chk(nm, e, q);
   endtask : rd
   // let registered controls land
   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle
   // reset values, unmapped slot, direction and text fields
   task automatic t_regs;
      chk("pin idle", 1, intr_pin);
      rd(A_MAC, 0, "mac reset");
      rd(A_ICR, 0, "icr reset");
      rd(8'h20, 0, "unmapped");
      chk("pslverr", 1, err_q);
      for (int c = 0; c < 4; c++)
      begin
         wr(A_MAC, {c[1:0], c[1:0], 1'h1, c[1:0], 1'h0}); // bit0 kept zero
         rd(A_MAC, {c[1:0], c[1:0], 1'h0, c[1:0], 1'h0}, "mac");
         chk("rdir", c, read_dir);
         chk("wdir", c, write_dir);
      end
      wr(hmpic_pkg::ADDR_CANVAS, 1);
      wr(A_ICR, 8'h04);
      settle;
      chk("rdir lin", 0, read_dir);
      chk("wdir lin", 0, write_dir);
      chk("text lin", 0, text_mode);
      wr(hmpic_pkg::ADDR_CANVAS, 0);
      settle;
      chk("text", 1, text_mode);
   endtask : t_regs
   // format codes on an even then an odd word; direct first as a narrow host would
   task automatic t_format;
      for (int f = 0; f < 4; f++)
      begin
         wr(A_MAC, {f[1:0], 6'h00});
         wr(A_ICR, 0);
         host.access(1'h1, 16'hA5C3);
         #1;
         chk("fmt even", (f < 2) ? 32'hA5C3 : 32'h00C3, mem_data);
         chk("fmt out", f, img_format);
         host.access(1'h1, 16'hA5C3);
         #1;
         chk("fmt odd", (f == 2) ? 32'h00C3 : 32'hA5C3, mem_data);
      end
      wr(A_MAC, 0);
   endtask : t_format
   // every destination: write shaping and read refusal
   task automatic t_dest;
      for (int d = 0; d < 4; d++)
      begin
         wr(A_ICR, d);
         host.access(1'h1, 16'hA5C3);
         #1;
         chk("dest wr", 1, mem_wr);
         chk("dest data", (d == 0) ? 32'hA5C3 : (d == 3) ? 32'h0003 : 32'h00C3, mem_data);
         chk("dest be", (d == 0) ? 32'h3 : 32'h1, mem_be);
         chk("dest out", d, mem_dest);
         host.access(1'h0, 16'h0000);
         #1;
         chk("dest rd", d < 2, mem_rd);
         chk("dest refused", d >= 2, mem_refused);
      end
   endtask : t_dest
   // refused read asserts the pin low; polarity, mask and clear
   task automatic t_irq;
      wr(A_STA, 3);
      wr(A_MSK, 2);
      host.access(1'h0, 16'h0000);
      settle;
      rd(A_STA, 2, "status");
      chk("pin low act", 0, intr_pin);
      wr(A_ICR, 8'h82);
      settle;
      chk("pin high act", 1, intr_pin);
      wr(A_MSK, 0);
      settle;
      chk("pin masked", 0, intr_pin);
      wr(A_MSK, 2);
      wr(A_STA, 2);
      settle;
      chk("pin cleared", 0, intr_pin);
      rd(A_STA, 0, "status clr");
   endtask : t_irq
   // each trigger type; level keeps setting status, an edge only once
   task automatic t_trig;
      wr(A_MSK, 1);
      for (int t = 0; t < 4; t++)
      begin
         @(posedge pclk);
         ext <= ~t[1];
         wr(A_ICR, {2'h0, t[1:0], 4'h0});
         settle;
         wr(A_STA, 1);
         rd(A_STA, 0, "trig idle");
         @(posedge pclk);
         ext <= t[1];
         rd(A_STA, 1, "trig hit");
         wr(A_STA, 1);
         rd(A_STA, t[0] ? 0 : 1, "trig held");
      end
   endtask : t_trig
   // debounce: a short pulse is dropped, a long one passes
   task automatic t_deb;
      @(posedge pclk);
      ext <= 1'h0;
      wr(A_ICR, 8'h60);
      settle;
      wr(A_STA, 1);
      ext <= 1'h1;
      repeat (990) @(posedge pclk);
      ext <= 1'h0;
      rd(A_STA, 0, "deb short");
      ext <= 1'h1;
      repeat (1100) @(posedge pclk);
      rd(A_STA, 1, "deb long");
   endtask : t_deb
   // reset for six cycles, then the scenarios
   initial
   begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext = 1'h1;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      #1;
      t_regs;
      t_format;
      t_dest;
      t_irq;
      t_trig;
      t_deb;
      end_sim;
   end
endmodule : host_memory_port_input_control_test
